//--- tcu_timer_unit.sv
`timescale 1ns/100ps
// Contract
// RQ1 - bus is byte wide; a 16-bit write stores only its lower byte
// RQ2 - upper byte of a 16-bit read is undefined; driven as zero here
// RQ3 - watchdog control reads E6 after watchdog reset, E4 otherwise
// RQ4 - unimplemented bits read zero; software must not write ones there
// RQ5 - shared timer clock is oscillator divided by 4, 16 or 64
// RQ6 - one prescaler setting drives all three timers and the watchdog
// RQ7 - each timer selects internal clock or external events on its own
// RQ8 - timers count upward unless a mode says otherwise
// RQ9 - counter mode increments on each falling edge of its pin
// RQ10 - pins sampled every two oscillator cycles, detection within four
// RQ11 - external source holds each level at least two oscillator cycles
// RQ12 - count registers readable while running without stopping them
// RQ13 - pin synchronised, then falling edge found between successive samples
module tcu_timer_unit (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [10:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [15:0] sfrWrData,
  input wire logic wdtResetCause,
  input wire logic t0Pin,
  input wire logic t1Pin,
  input wire logic t2Pin,
  output logic [15:0] sfrRdData,
  output logic sfrRdValid,
  output logic sharedTimerTick,
  output logic [7:0] watchdogReload,
  output logic [2:0] watchdogPrescale
);

  logic [7:0] tconReg, tconNext;
  logic [7:0] tstatReg, tstatNext;
  logic [7:0] t2conReg, t2conNext;
  logic [7:0] t2modReg, t2modNext;
  logic [7:0] wdconReg, wdconNext;
  logic [7:0] wdlReg, wdlNext;
  logic [7:0] tmodReg, tmodNext;
  logic [7:0] scrReg, scrNext;
  logic [7:0] capLowReg, capLowNext;
  logic [7:0] capHighReg, capHighNext;
  logic [5:0] presCntReg, presCntNext;
  logic [5:0] presLast;
  logic tickReg, tickNext;
  tcu_pkg::tcu_sample_phase_e phaseReg, phaseNext;
  logic [15:0] rdDataReg, rdDataNext;
  logic rdValidReg;
  logic [7:0] wrByte;
  logic [1:0] presSel;
  logic [15:0] count0, count1, count2;
  logic ovf0, ovf1, ovf2;
  logic run0, run1, run2;
  logic sampleTick;

  assign wrByte = sfrWrData[7:0]; // upper byte dropped [RQ1]
  assign presSel = {scrReg[tcu_pkg::PRESCALE_SEL_HI_BIT], scrReg[tcu_pkg::PRESCALE_SEL_LO_BIT]};
  assign sampleTick = (phaseReg == tcu_pkg::SAMPLE_TAKE);
  assign run0 = tconReg[tcu_pkg::TR0_BIT];
  // timer 1 holds its count in mode 3, as if stopped
  assign run1 = tconReg[tcu_pkg::TR1_BIT] && (tmodReg[5:4] != tcu_pkg::TIMER_MODE_HOLD);
  assign run2 = t2conReg[tcu_pkg::TR2_BIT];

  // time base shared by every timer and the watchdog
  always_comb begin
    case (presSel) // [RQ5]
      2'h0: presLast = tcu_pkg::PRESCALE_LAST_DIV4;
      2'h1: presLast = tcu_pkg::PRESCALE_LAST_DIV16;
      // reserved setting falls back to the slowest rate
      default: presLast = tcu_pkg::PRESCALE_LAST_DIV64;
    endcase
    // >= guards against a runaway when the rate is raised mid-count
    if (presCntReg >= presLast) begin
      presCntNext = tcu_pkg::PRESCALE_RESET;
      tickNext = 1'b1; // [RQ6]
    end else begin
      presCntNext = presCntReg + 6'h01;
      tickNext = 1'b0;
    end
    case (phaseReg) // [RQ10]
      tcu_pkg::SAMPLE_WAIT: phaseNext = tcu_pkg::SAMPLE_TAKE;
      tcu_pkg::SAMPLE_TAKE: phaseNext = tcu_pkg::SAMPLE_WAIT;
      default: phaseNext = tcu_pkg::SAMPLE_WAIT;
    endcase
  end

  // register writes; hardware flag sets win over a software clear
  always_comb begin
    tconNext = tconReg;
    tstatNext = tstatReg;
    t2conNext = t2conReg;
    t2modNext = t2modReg;
    wdconNext = wdconReg;
    wdlNext = wdlReg;
    tmodNext = tmodReg;
    scrNext = scrReg;
    capLowNext = capLowReg;
    capHighNext = capHighReg;
    if (sfrWrEn) begin
      case (sfrAddr) // [RQ1]
        tcu_pkg::ADDR_TIMER01_CONTROL: tconNext = wrByte;
        tcu_pkg::ADDR_TIMER01_EXT_STATUS: tstatNext = wrByte & tcu_pkg::MASK_TIMER01_EXT_STATUS;
        tcu_pkg::ADDR_TIMER2_CONTROL: t2conNext = wrByte;
        tcu_pkg::ADDR_TIMER2_MODE: t2modNext = wrByte & tcu_pkg::MASK_TIMER2_MODE; // [RQ4]
        tcu_pkg::ADDR_WATCHDOG_CONTROL: wdconNext = wrByte & tcu_pkg::MASK_WATCHDOG_CONTROL;
        tcu_pkg::ADDR_WATCHDOG_RELOAD: wdlNext = wrByte;
        tcu_pkg::ADDR_TIMER01_MODE: tmodNext = wrByte;
        tcu_pkg::ADDR_SYSTEM_CONFIG_REG: scrNext = wrByte & tcu_pkg::MASK_SYSTEM_CONFIG_REG;
        tcu_pkg::ADDR_TIMER2_CAPTURE_LOW: capLowNext = wrByte;
        tcu_pkg::ADDR_TIMER2_CAPTURE_HIGH: capHighNext = wrByte;
        default: tconNext = tconReg;
      endcase
    end
    if (ovf0) begin
      tconNext[tcu_pkg::TF0_BIT] = 1'b1;
    end
    if (ovf1) begin
      tconNext[tcu_pkg::TF1_BIT] = 1'b1;
    end
    if (ovf2) begin
      t2conNext[tcu_pkg::TF2_BIT] = 1'b1;
    end
  end

  // read mux; counts are read live without pausing them
  always_comb begin
    rdDataNext = rdDataReg;
    if (sfrRdEn) begin
      rdDataNext[15:8] = tcu_pkg::RESET_BYTE; // [RQ2]
      case (sfrAddr)
        tcu_pkg::ADDR_TIMER01_CONTROL: rdDataNext[7:0] = tconReg;
        tcu_pkg::ADDR_TIMER01_EXT_STATUS: rdDataNext[7:0] = tstatReg;
        tcu_pkg::ADDR_TIMER2_CONTROL: rdDataNext[7:0] = t2conReg;
        tcu_pkg::ADDR_TIMER2_MODE: rdDataNext[7:0] = t2modReg;
        tcu_pkg::ADDR_WATCHDOG_CONTROL: rdDataNext[7:0] = wdconReg;
        tcu_pkg::ADDR_SYSTEM_CONFIG_REG: rdDataNext[7:0] = scrReg;
        tcu_pkg::ADDR_TIMER0_COUNT_LOW: rdDataNext[7:0] = count0[7:0]; // [RQ12]
        tcu_pkg::ADDR_TIMER0_COUNT_HIGH: rdDataNext[7:0] = count0[15:8];
        tcu_pkg::ADDR_TIMER1_COUNT_LOW: rdDataNext[7:0] = count1[7:0];
        tcu_pkg::ADDR_TIMER1_COUNT_HIGH: rdDataNext[7:0] = count1[15:8];
        tcu_pkg::ADDR_TIMER2_COUNT_LOW: rdDataNext[7:0] = count2[7:0];
        tcu_pkg::ADDR_TIMER2_COUNT_HIGH: rdDataNext[7:0] = count2[15:8];
        tcu_pkg::ADDR_TIMER2_CAPTURE_LOW: rdDataNext[7:0] = capLowReg;
        tcu_pkg::ADDR_TIMER2_CAPTURE_HIGH: rdDataNext[7:0] = capHighReg;
        tcu_pkg::ADDR_TIMER01_MODE: rdDataNext[7:0] = tmodReg;
        tcu_pkg::ADDR_WATCHDOG_RELOAD: rdDataNext[7:0] = wdlReg;
        // feed registers are write-only; unmapped reads give zero
        default: rdDataNext[7:0] = tcu_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tconReg <= tcu_pkg::RESET_BYTE;
      tstatReg <= tcu_pkg::RESET_BYTE;
      t2conReg <= tcu_pkg::RESET_BYTE;
      t2modReg <= tcu_pkg::RESET_BYTE;
      // synchronous reset, so the cause input may be sampled here [RQ3]
      wdconReg <= wdtResetCause ? tcu_pkg::WATCHDOG_CONTROL_RESET_WATCHDOG : tcu_pkg::WATCHDOG_CONTROL_RESET_OTHER;
      wdlReg <= tcu_pkg::RESET_BYTE;
      tmodReg <= tcu_pkg::RESET_BYTE;
      scrReg <= tcu_pkg::RESET_BYTE;
      capLowReg <= tcu_pkg::RESET_BYTE;
      capHighReg <= tcu_pkg::RESET_BYTE;
      presCntReg <= tcu_pkg::PRESCALE_RESET;
      tickReg <= 1'b0;
      phaseReg <= tcu_pkg::SAMPLE_WAIT;
      rdDataReg <= tcu_pkg::RESET_COUNT;
      rdValidReg <= 1'b0;
    end else begin
      tconReg <= tconNext;
      tstatReg <= tstatNext;
      t2conReg <= t2conNext;
      t2modReg <= t2modNext;
      wdconReg <= wdconNext;
      wdlReg <= wdlNext;
      tmodReg <= tmodNext;
      scrReg <= scrNext;
      capLowReg <= capLowNext;
      capHighReg <= capHighNext;
      presCntReg <= presCntNext;
      tickReg <= tickNext;
      phaseReg <= phaseNext;
      rdDataReg <= rdDataNext;
      rdValidReg <= sfrRdEn;
    end
  end

  tcu_timer_counter timer0 (
    .ref_clk(ref_clk),
    .rst(rst),
    .countPin(t0Pin),
    .sampleTick(sampleTick),
    .timerTick(tickReg),
    .useCounter(tmodReg[tcu_pkg::CT0_BIT]),
    .run(run0),
    .wrLow(sfrWrEn && (sfrAddr == tcu_pkg::ADDR_TIMER0_COUNT_LOW)),
    .wrHigh(sfrWrEn && (sfrAddr == tcu_pkg::ADDR_TIMER0_COUNT_HIGH)),
    .wrData(wrByte),
    .count(count0),
    .overflow(ovf0)
  );

  tcu_timer_counter timer1 (
    .ref_clk(ref_clk),
    .rst(rst),
    .countPin(t1Pin),
    .sampleTick(sampleTick),
    .timerTick(tickReg),
    .useCounter(tmodReg[tcu_pkg::CT1_BIT]),
    .run(run1),
    .wrLow(sfrWrEn && (sfrAddr == tcu_pkg::ADDR_TIMER1_COUNT_LOW)),
    .wrHigh(sfrWrEn && (sfrAddr == tcu_pkg::ADDR_TIMER1_COUNT_HIGH)),
    .wrData(wrByte),
    .count(count1),
    .overflow(ovf1)
  );

  tcu_timer_counter timer2 (
    .ref_clk(ref_clk),
    .rst(rst),
    .countPin(t2Pin),
    .sampleTick(sampleTick),
    .timerTick(tickReg),
    .useCounter(t2conReg[tcu_pkg::CT2_BIT]),
    .run(run2),
    .wrLow(sfrWrEn && (sfrAddr == tcu_pkg::ADDR_TIMER2_COUNT_LOW)),
    .wrHigh(sfrWrEn && (sfrAddr == tcu_pkg::ADDR_TIMER2_COUNT_HIGH)),
    .wrData(wrByte),
    .count(count2),
    .overflow(ovf2)
  );

  assign sfrRdData = rdDataReg;
  assign sfrRdValid = rdValidReg;
  assign sharedTimerTick = tickReg;
  assign watchdogReload = wdlReg;
  assign watchdogPrescale = wdconReg[7:5];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_WR_LOW_BYTE: assert property ( // [RQ1]
    sfrWrEn && sfrAddr == tcu_pkg::ADDR_TIMER01_MODE |=> tmodReg == $past(sfrWrData[7:0]))
    else $error("16-bit write did not store exactly the low byte");
  AST_RD_UPPER_ZERO: assert property ( // [RQ2]
    sfrRdEn |=> sfrRdValid && sfrRdData[15:8] == 8'h00)
    else $error("read answer missing or upper byte not zero");
  AST_WATCHDOG_CONTROL_RESET: assert property ( // [RQ3]
    $fell(rst) |-> wdconReg == ($past(wdtResetCause) ? 8'hE6 : 8'hE4))
    else $error("watchdog control reset value does not match reset cause");
  AST_UNIMP_ZERO: assert property ( // [RQ4]
    (tstatReg & 8'hFA) == 8'h00 && (t2modReg & 8'hCC) == 8'h00 && (scrReg & 8'hF0) == 8'h00)
    else $error("unimplemented bit holds a one");
  AST_TICK_DIV4: assert property ( // [RQ5]
    (tickReg && presSel == 2'h0) ##1 (presSel == 2'h0)[*3] |=> tickReg)
    else $error("divide-by-4 time base period wrong");
  AST_TICK_GAP: assert property ( // [RQ5]
    tickReg |=> !tickReg[*3])
    else $error("time base ticks closer than four cycles");
  AST_TIMER_STEP: assert property ( // [RQ6]
    tickReg && run0 && !tmodReg[2] && !sfrWrEn |=> count0 == $past(count0) + 16'h0001)
    else $error("timer mode did not step on shared tick");
  AST_COUNT_UP: assert property ( // [RQ8]
    !sfrWrEn |=> (count2 == $past(count2)) || (count2 == $past(count2) + 16'h0001))
    else $error("timer moved other than up by one");
  AST_EDGE_LATENCY: assert property ( // [RQ9]
    $fell(t0Pin) && run0 && tmodReg[2] && !sfrWrEn ##1 (!t0Pin && !sfrWrEn)[*3]
    |=> count0 != $past(count0, 4))
    else $error("falling edge on count pin not counted within four cycles");
  AST_NO_EDGE_NO_COUNT: assert property ( // [RQ7]
    run0 && tmodReg[2] && !sfrWrEn && !tickReg |=> count0 == $past(count0) || $past(sampleTick))
    else $error("counter mode stepped outside a sample slot");
  AST_FLAG_SET_WINS: assert property (
    ovf0 && sfrWrEn && sfrAddr == tcu_pkg::ADDR_TIMER01_CONTROL |=> tconReg[5])
    else $error("overflow flag lost against software clear");
  AST_RD_LIVE: assert property ( // [RQ12]
    sfrRdEn && sfrAddr == tcu_pkg::ADDR_TIMER0_COUNT_LOW |=> sfrRdData[7:0] == $past(count0[7:0]))
    else $error("live count read wrong");
  AST_READ_HOLD: assert property ( // [RQ2]
    !sfrRdEn |=> sfrRdData == $past(sfrRdData))
    else $error("read data changed without a read");
  AST_SAMPLE_SKIP: assert property ( // [RQ10]
    sampleTick |=> !sampleTick)
    else $error("count pins sampled in two cycles in a row");
  AST_SAMPLE_NEXT: assert property ( // [RQ10]
    !sampleTick |=> sampleTick)
    else $error("count pin sample slot skipped");
  AST_TF0_SET: assert property (
    ovf0 |=> tconReg[tcu_pkg::TF0_BIT])
    else $error("timer 0 overflow did not set its flag");
  AST_T1_HOLD: assert property (
    tmodReg[5:4] == tcu_pkg::TIMER_MODE_HOLD && !sfrWrEn |=> count1 == $past(count1))
    else $error("timer 1 moved while its mode holds the count");

  COV_OVERFLOW0: cover property (ovf0 ##1 tconReg[5]);
  COV_COUNTER_EDGE: cover property (run1 && tmodReg[6] ##1 count1 != $past(count1));
  COV_DIV64: cover property (tickReg && presSel == 2'h2);
  COV_WDT_CAUSE: cover property ($fell(rst) && wdconReg == 8'hE6);
  COV_T1_HELD: cover property (tconReg[tcu_pkg::TR1_BIT] && !run1);

endmodule : tcu_timer_unit

//--- tcu_pkg.sv
package tcu_pkg;

  // byte addresses on the special function register bus
  localparam logic [10:0] ADDR_TIMER01_CONTROL = 11'h410;
  localparam logic [10:0] ADDR_TIMER01_EXT_STATUS = 11'h411;
  localparam logic [10:0] ADDR_TIMER2_CONTROL = 11'h418;
  localparam logic [10:0] ADDR_TIMER2_MODE = 11'h419;
  localparam logic [10:0] ADDR_WATCHDOG_CONTROL = 11'h41F;
  localparam logic [10:0] ADDR_SYSTEM_CONFIG_REG = 11'h440;
  localparam logic [10:0] ADDR_TIMER0_COUNT_LOW = 11'h450;
  localparam logic [10:0] ADDR_TIMER0_COUNT_HIGH = 11'h451;
  localparam logic [10:0] ADDR_TIMER1_COUNT_LOW = 11'h452;
  localparam logic [10:0] ADDR_TIMER1_COUNT_HIGH = 11'h453;
  localparam logic [10:0] ADDR_TIMER2_COUNT_LOW = 11'h458;
  localparam logic [10:0] ADDR_TIMER2_COUNT_HIGH = 11'h459;
  localparam logic [10:0] ADDR_TIMER2_CAPTURE_LOW = 11'h45A;
  localparam logic [10:0] ADDR_TIMER2_CAPTURE_HIGH = 11'h45B;
  localparam logic [10:0] ADDR_TIMER01_MODE = 11'h45C;
  localparam logic [10:0] ADDR_WATCHDOG_FEED_FIRST = 11'h45D;
  localparam logic [10:0] ADDR_WATCHDOG_FEED_SECOND = 11'h45E;
  localparam logic [10:0] ADDR_WATCHDOG_RELOAD = 11'h45F;

  // implemented-bit masks; other bits store nothing and read zero
  localparam logic [7:0] MASK_TIMER01_EXT_STATUS = 8'h05;
  localparam logic [7:0] MASK_TIMER2_MODE = 8'h33;
  localparam logic [7:0] MASK_WATCHDOG_CONTROL = 8'hE6;
  localparam logic [7:0] MASK_SYSTEM_CONFIG_REG = 8'h0F;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_COUNT = 16'h0000;
  localparam logic [7:0] WATCHDOG_CONTROL_RESET_WATCHDOG = 8'hE6;
  localparam logic [7:0] WATCHDOG_CONTROL_RESET_OTHER = 8'hE4;

  // field positions
  localparam int TF1_BIT = 7;
  localparam int TR1_BIT = 6;
  localparam int TF0_BIT = 5;
  localparam int TR0_BIT = 4;
  localparam int TF2_BIT = 7;
  localparam int TR2_BIT = 2;
  localparam int CT2_BIT = 1;
  localparam int CT0_BIT = 2;
  localparam int CT1_BIT = 6;
  localparam int PRESCALE_SEL_HI_BIT = 3;
  localparam int PRESCALE_SEL_LO_BIT = 2;
  localparam logic [1:0] TIMER_MODE_HOLD = 2'h3;

  // time base: oscillator is ref_clk, last prescaler count per divide
  localparam logic [5:0] PRESCALE_LAST_DIV4 = 6'h03;
  localparam logic [5:0] PRESCALE_LAST_DIV16 = 6'h0F;
  localparam logic [5:0] PRESCALE_LAST_DIV64 = 6'h3F;
  localparam logic [5:0] PRESCALE_RESET = 6'h00;

  typedef enum logic [0:0] {
    SAMPLE_WAIT = 1'b0,
    SAMPLE_TAKE = 1'b1
  } tcu_sample_phase_e;

endpackage : tcu_pkg

//--- tcu_timer_counter.sv
`timescale 1ns/100ps
module tcu_timer_counter (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic countPin,
  input wire logic sampleTick,
  input wire logic timerTick,
  input wire logic useCounter,
  input wire logic run,
  input wire logic wrLow,
  input wire logic wrHigh,
  input wire logic [7:0] wrData,
  output logic [15:0] count,
  output logic overflow
);

  logic syncFirstReg;
  logic syncSecondReg;
  logic sampledReg;
  logic sampledNext;
  logic [15:0] countReg;
  logic [15:0] countNext;
  logic overflowReg;
  logic overflowNext;
  logic pinFell;
  logic step;

  always_comb begin
    sampledNext = sampledReg;
    pinFell = 1'b0;
    // compare samples taken every other oscillator cycle [RQ10] [RQ13]
    if (sampleTick) begin
      sampledNext = syncSecondReg;
      pinFell = sampledReg && !syncSecondReg; // [RQ9]
    end
    step = run && (useCounter ? pinFell : timerTick); // [RQ7]
    countNext = countReg;
    overflowNext = 1'b0;
    if (step) begin
      countNext = countReg + 16'h0001; // [RQ8]
      overflowNext = (countReg == 16'hFFFF);
    end
    // in the written byte, a software write beats a count in the same cycle; the other byte still steps
    if (wrLow) begin
      countNext[7:0] = wrData;
    end
    if (wrHigh) begin
      countNext[15:8] = wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncFirstReg <= 1'b1;
      syncSecondReg <= 1'b1;
      sampledReg <= 1'b1;
      countReg <= tcu_pkg::RESET_COUNT;
      overflowReg <= 1'b0;
    end else begin
      syncFirstReg <= countPin; // [RQ13]
      syncSecondReg <= syncFirstReg;
      sampledReg <= sampledNext;
      countReg <= countNext;
      overflowReg <= overflowNext;
    end
  end

  assign count = countReg;
  assign overflow = overflowReg;

endmodule : tcu_timer_counter

//--- tcu_cpu_model.sv
`timescale 1ns/100ps
module tcu_cpu_model (
  input wire logic ref_clk,
  output logic [10:0] sfrAddr,
  output logic sfrWrEn,
  output logic sfrRdEn,
  output logic [15:0] sfrWrData
);
  initial begin
    sfrAddr = 11'h000;
    sfrWrEn = 1'b0;
    sfrRdEn = 1'b0;
    sfrWrData = 16'h0000;
  end

  // one strobe cycle per access; released lines are inverted so a stale value never looks valid
  task automatic wr(input logic [10:0] addr, input logic [15:0] data);
    @(posedge ref_clk);
    #1;
    sfrAddr = addr;
    sfrWrData = data;
    sfrWrEn = 1'b1;
    @(posedge ref_clk);
    #1;
    sfrWrEn = 1'b0;
    sfrAddr = ~addr;
    sfrWrData = ~data;
  endtask : wr

  task automatic rd(input logic [10:0] addr);
    @(posedge ref_clk);
    #1;
    sfrAddr = addr;
    sfrRdEn = 1'b1;
    @(posedge ref_clk);
    #1;
    sfrRdEn = 1'b0;
    sfrAddr = ~addr;
  endtask : rd
endmodule : tcu_cpu_model

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wdtResetCause = 1'b0;
  logic [2:0] pins = 3'h7;
  logic [10:0] sfrAddr;
  logic sfrWrEn;
  logic sfrRdEn;
  logic [15:0] sfrWrData;
  logic [15:0] sfrRdData;
  logic sfrRdValid;
  logic sharedTimerTick;
  logic [7:0] watchdogReload;
  logic [2:0] watchdogPrescale;
  logic [15:0] expQ[$];
  logic [31:0] rngState = 32'h0000_0002;
  int err_total = 0;
  int checks = 0;
  logic [10:0] regA [16] = '{11'h411, 11'h419, 11'h41F, 11'h440, 11'h450, 11'h451, 11'h452,
    11'h453, 11'h458, 11'h459, 11'h45A, 11'h45B, 11'h45C, 11'h45F, 11'h45D, 11'h7FF};
  logic [7:0] regM [16] = '{8'h05, 8'h33, 8'hE6, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
  logic [10:0] lowA [3] = '{11'h450, 11'h452, 11'h458};

  always #50 ref_clk = ~ref_clk;

  tcu_cpu_model tcu_cpu_model_inst (.ref_clk(ref_clk), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData));

  tcu_timer_unit tcu_timer_unit_inst (.ref_clk(ref_clk), .rst(rst), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData),
    .wdtResetCause(wdtResetCause), .t0Pin(pins[0]), .t1Pin(pins[1]), .t2Pin(pins[2]),
    .sfrRdData(sfrRdData), .sfrRdValid(sfrRdValid), .sharedTimerTick(sharedTimerTick),
    .watchdogReload(watchdogReload), .watchdogPrescale(watchdogPrescale));

  function automatic logic [31:0] xs();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction : xs

  task automatic check(input logic [15:0] seen, input logic [15:0] expVal, input string what);
    checks++;
    if (seen !== expVal) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h wanted %h", $time, what, seen, expVal);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // read results arrive a cycle after the strobe; the oldest note is matched to each one
  always @(posedge ref_clk) begin
    if (sfrRdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        err_total++;
        $display("unexpected at %0t: read data with no request", $time);
      end else begin
        check(sfrRdData, expQ.pop_front(), "read data");
      end
    end
  end

  task automatic rd_exp(input logic [10:0] a, input logic [15:0] e);
    expQ.push_back(e);
    tcu_cpu_model_inst.rd(a);
  endtask : rd_exp

  task automatic wr_rnd(input logic [10:0] a, input logic [7:0] b);
    logic [31:0] r;
    r = xs();
    tcu_cpu_model_inst.wr(a, {r[15:8], b});
  endtask : wr_rnd

  task automatic do_reset(input logic cause);
    @(posedge ref_clk);
    #1;
    rst = 1'b1;
    wdtResetCause = cause;
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    wdtResetCause = 1'b0;
  endtask : do_reset

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (sharedTimerTick !== 1'b1 && n < 200);
    if (n >= 200) begin
      err_total++;
      $display("unexpected at %0t: shared tick missing", $time);
      report_and_stop();
    end
  endtask : wait_tick

  task automatic reset_values(input logic cause);
    logic [7:0] wd;
    logic [15:0] e;
    do_reset(cause);
    wd = cause ? 8'hE6 : 8'hE4;
    for (int i = 0; i < 16; i++) begin
      e = (regA[i] == tcu_pkg::ADDR_WATCHDOG_CONTROL) ? {8'h00, wd} : 16'h0000;
      rd_exp(regA[i], e);
    end
    rd_exp(tcu_pkg::ADDR_TIMER01_CONTROL, 16'h0000);
    rd_exp(tcu_pkg::ADDR_TIMER2_CONTROL, 16'h0000);
    check({13'h0000, watchdogPrescale}, {13'h0000, wd[7:5]}, "prescale out");
    $display("test reset values done");
  endtask : reset_values

  initial begin
    int n;
    int cnt [3];
    int h;
    logic [31:0] r;
    reset_values(1'b0);
    for (int i = 0; i < 16; i++) begin
      r = xs();
      // software keeps unimplemented bits zero; refused places get a full random byte
      wr_rnd(regA[i], (regM[i] == 8'h00) ? r[7:0] : (r[7:0] & regM[i]));
      rd_exp(regA[i], {8'h00, r[7:0] & regM[i]});
      if (regA[i] == tcu_pkg::ADDR_WATCHDOG_CONTROL) begin
        check({13'h0000, watchdogPrescale}, {13'h0000, r[7:5]}, "prescale out");
      end
      if (regA[i] == tcu_pkg::ADDR_WATCHDOG_RELOAD) begin
        check({8'h00, watchdogReload}, {8'h00, r[7:0]}, "reload out");
      end
    end
    $display("test register access done");
    reset_values(1'b1);
    for (int s = 0; s < 4; s++) begin
      wr_rnd(tcu_pkg::ADDR_SYSTEM_CONFIG_REG, {4'h0, s[1:0], 2'h0});
      repeat (3) wait_tick(n);
      check(16'(n), (s == 0) ? 16'h0004 : (s == 1) ? 16'h0010 : 16'h0040, "tick period");
    end
    $display("test prescaler done");
    do_reset(1'b0);
    wr_rnd(tcu_pkg::ADDR_SYSTEM_CONFIG_REG, 8'h08);
    wait_tick(n);
    // start lands just after a tick and stop well between ticks, so the step count is exact
    wr_rnd(tcu_pkg::ADDR_TIMER01_CONTROL, 8'h50);
    wr_rnd(tcu_pkg::ADDR_TIMER2_CONTROL, 8'h04);
    repeat (160) @(posedge ref_clk);
    rd_exp(tcu_pkg::ADDR_TIMER0_COUNT_LOW, 16'h0002);
    repeat (180) @(posedge ref_clk);
    wr_rnd(tcu_pkg::ADDR_TIMER01_CONTROL, 8'h00);
    wr_rnd(tcu_pkg::ADDR_TIMER2_CONTROL, 8'h00);
    for (int t = 0; t < 3; t++) begin
      rd_exp(lowA[t], 16'h0005);
      rd_exp(lowA[t] + 11'h001, 16'h0000);
    end
    $display("test shared time base done");
    do_reset(1'b0);
    wr_rnd(tcu_pkg::ADDR_TIMER01_MODE, 8'h44);
    wr_rnd(tcu_pkg::ADDR_TIMER2_CONTROL, 8'h06);
    wr_rnd(tcu_pkg::ADDR_TIMER01_CONTROL, 8'h50);
    for (int p = 0; p < 3; p++) begin
      r = xs();
      cnt[p] = 1 + int'(r[2:0]);
      for (int k = 0; k < cnt[p]; k++) begin
        r = xs();
        h = 2 + int'(r[1:0] % 3);
        pins[p] = 1'b0;
        repeat (h) @(posedge ref_clk);
        #1;
        pins[p] = 1'b1;
        repeat (h) @(posedge ref_clk);
        #1;
      end
    end
    repeat (8) @(posedge ref_clk);
    for (int p = 0; p < 3; p++) begin
      rd_exp(lowA[p], 16'(cnt[p]));
    end
    $display("test event counting done");
    do_reset(1'b0);
    wr_rnd(tcu_pkg::ADDR_TIMER01_MODE, 8'h30);
    wr_rnd(tcu_pkg::ADDR_TIMER0_COUNT_LOW, 8'hFE);
    wr_rnd(tcu_pkg::ADDR_TIMER0_COUNT_HIGH, 8'hFF);
    // timer 1 sits in its holding mode while timer 0 wraps and must raise its flag
    wr_rnd(tcu_pkg::ADDR_TIMER01_CONTROL, 8'h50);
    repeat (40) @(posedge ref_clk);
    rd_exp(tcu_pkg::ADDR_TIMER01_CONTROL, 16'h0070);
    rd_exp(tcu_pkg::ADDR_TIMER0_COUNT_HIGH, 16'h0000);
    rd_exp(tcu_pkg::ADDR_TIMER1_COUNT_LOW, 16'h0000);
    $display("test overflow and hold done");
    repeat (4) @(posedge ref_clk);
    check(16'(expQ.size()), 16'h0000, "reads left unanswered");
    report_and_stop();
  end
endmodule : tb_top
